/* shared/asrd_pkg.sv */
// Package for the address space region decoder: region and window
// codes, address prefixes and external area numbers.
// Assumes a 32-bit core address and a 29-bit external bus address.

package asrd_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ASRD_VA_W = 32; // Core address width
	localparam int ASRD_EXT_W = 29; // External address width
	localparam int ASRD_ADDRESS_SPACE_IDENTIFIER_W = 8; // Address space identifier width
	localparam int ASRD_SA_W = 3; // Space attribute width

	// ------------------------------------------------------------
	// Address prefixes
	// ------------------------------------------------------------
	localparam logic [2:0] ASRD_TOP_CACHED = 3'h4; // Bits 31:29 = 100
	localparam logic [2:0] ASRD_TOP_UNCACHED = 3'h5; // Bits 31:29 = 101
	localparam logic [2:0] ASRD_TOP_THIRD = 3'h6; // Bits 31:29 = 110
	localparam logic [2:0] ASRD_TOP_ONCHIP = 3'h7; // Bits 31:29 = 111
	localparam logic [5:0] ASRD_SQ_PREFIX = 6'h38; // E000_0000..E3FF_FFFF
	localparam logic [4:0] ASRD_ARRAY_PREFIX = 5'h1E; // F000_0000..F7FF_FFFF
	localparam logic [5:0] ASRD_RSV_PREFIX = 6'h3E; // F800_0000..FBFF_FFFF
	localparam logic [5:0] ASRD_CTRL_PREFIX = 6'h3F; // FC00_0000..FFFF_FFFF
	localparam logic [7:0] ASRD_PERIPH_PREFIX = 8'hFF; // FF00_0000..FFFF_FFFF
	localparam logic [5:0] ASRD_RAM_PREFIX = 6'h1F; // 7C00_0000..7FFF_FFFF

	// ------------------------------------------------------------
	// External areas, selected by external bits 28:26
	// ------------------------------------------------------------
	localparam logic [2:0] ASRD_AREA_RESERVED = 3'h7; // Area 7
	localparam logic [2:0] ASRD_AREA_PCMCIA_A = 3'h5; // Area 5
	localparam logic [2:0] ASRD_AREA_PCMCIA_B = 3'h6; // Area 6

	// Region of a core address
	typedef enum logic [2:0] {
		ASRD_REG_LOW,
		ASRD_REG_CACHED,
		ASRD_REG_UNCACHED,
		ASRD_REG_THIRD,
		ASRD_REG_ONCHIP
	} asrd_region_e;

	// Window inside the on-chip I/O region; array windows in address order
	typedef enum logic [3:0] {
		ASRD_WIN_NONE,
		ASRD_WIN_SQ,
		ASRD_WIN_RSV_LOW,
		ASRD_WIN_IC_ADDR,
		ASRD_WIN_IC_DATA,
		ASRD_WIN_ITLB_ADDR,
		ASRD_WIN_ITLB_DATA,
		ASRD_WIN_OC_ADDR,
		ASRD_WIN_OC_DATA,
		ASRD_WIN_UTLB_ADDR,
		ASRD_WIN_UTLB_DATA,
		ASRD_WIN_RSV_HIGH,
		ASRD_WIN_CTRL
	} asrd_window_e;

endpackage

/* shared/asrd_region_if.sv */
// Interface between the decoder top and its region classifier.
// Assumes both ends sit on the same clock; all signals are combinational.

`timescale 1ns/1ps

interface asrd_region_if;
	import asrd_pkg::*;
	logic [ASRD_VA_W-1:0] addr; // Address to classify
	asrd_region_e region; // Region of the address
	asrd_window_e window; // On-chip I/O window
	logic ram_hole; // Inside 7C00_0000..7FFF_FFFF
	logic periph; // Peripheral control registers

	modport classifier (input addr, output region, window, ram_hole, periph);
	modport decoder (output addr, input region, window, ram_hole, periph);
endinterface

/* logic/asrd_region_classify.sv */
// Region classifier: splits a core address into region and window.
// Assumes a purely combinational use; the caller registers the results.

`timescale 1ns/1ps

module asrd_region_classify
	import asrd_pkg::*;
(
	asrd_region_if.classifier rif
);

	// ------------------------------------------------------------
	// Prefix decode
	// ------------------------------------------------------------
	wire [2:0] top_bits = rif.addr[31:29]; // Region select field
	wire [5:0] pre6 = rif.addr[31:26]; // 64-Mbyte granule
	wire [4:0] pre5 = rif.addr[31:27]; // 128-Mbyte granule
	wire [2:0] arr_sel = rif.addr[26:24]; // Array window index
	wire in_sq = (pre6 == ASRD_SQ_PREFIX);
	wire in_arr = (pre5 == ASRD_ARRAY_PREFIX);
	wire in_rsv = (pre6 == ASRD_RSV_PREFIX);
	wire in_ctrl = (pre6 == ASRD_CTRL_PREFIX);

	// Region from bits 31:29
	always_comb begin
		unique case (top_bits)
			ASRD_TOP_CACHED: rif.region = ASRD_REG_CACHED;
			ASRD_TOP_UNCACHED: rif.region = ASRD_REG_UNCACHED;
			ASRD_TOP_THIRD: rif.region = ASRD_REG_THIRD;
			ASRD_TOP_ONCHIP: rif.region = ASRD_REG_ONCHIP;
			default: rif.region = ASRD_REG_LOW; // 0xx: low or user
		endcase
	end

	// Windows of the on-chip I/O region
	always_comb begin
		rif.window = ASRD_WIN_NONE;
		if (top_bits == ASRD_TOP_ONCHIP) begin
			if (in_sq) begin
				rif.window = ASRD_WIN_SQ;
			end else if (in_arr) begin
				// Eight 16-Mbyte windows in fixed order
				rif.window = asrd_window_e'(4'(ASRD_WIN_IC_ADDR) + 4'(arr_sel));
			end else if (in_rsv) begin
				rif.window = ASRD_WIN_RSV_HIGH;
			end else if (in_ctrl) begin
				rif.window = ASRD_WIN_CTRL;
			end else begin
				rif.window = ASRD_WIN_RSV_LOW; // E400_0000..EFFF_FFFF
			end
		end
	end

	// Hole excluded from cache and translation
	assign rif.ram_hole = (pre6 == ASRD_RAM_PREFIX);
	// Peripheral register block at the very top
	assign rif.periph = (rif.addr[31:24] == ASRD_PERIPH_PREFIX);

endmodule

/* logic/asrd_decoder.sv */
// Address space region decoder top: classifies each core or DMA access,
// chooses translation, cache use, write policy and PCMCIA attributes.
// Assumes the page lookup result is presented with the request, same clock.
//
// What this block does
// - Untranslated addresses pass straight as physical
// - External address drops top three bits
// - User mode limited to low 2 Gbytes and the store queue
// - Untranslated cache policy from cache control bits
// - Uncached privileged region never uses cache
// - Store queue window decoded, guarded untranslated
// - Eight uncached array windows decoded in order
// - Top block routed to control registers
// - External space split into eight areas
// - Translated regions go through page lookup
// - Translated accesses tagged with space identifier
// - Translated area 7 top reaches control registers
// - Hole 7C00_0000..7FFF_FFFF never cached nor translated
// - Translated caching needs enable and page bit
// - Translated write policy from page bit
// - Translated PCMCIA access takes page attributes
// - PCMCIA via untranslated or I/O regions blocked when translation is on
// - Untranslated PCMCIA takes assist register attributes
// - DMA PCMCIA always takes channel attributes
// - Fixed regions untranslated, except store queue
// - Privilege bit set makes untranslated user queue access error
// - Translation bit clear means no lookup

`timescale 1ns/1ps

module asrd_decoder
	import asrd_pkg::*;
#(
	parameter logic LEGACY_VARIANT = 1'b0 // Early part: no CPU PCMCIA when untranslated
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic req_valid_in, // Access request strobe
	input wire logic [ASRD_VA_W-1:0] req_addr_in, // Core or DMA address
	input wire logic req_user_in, // Core in user mode
	input wire logic req_dma_in, // Request comes from DMA
	input wire logic req_dma_dest_in, // DMA destination side
	input wire logic translation_enable_bit_in,
	input wire logic store_queue_privilege_bit_in,
	input wire logic cache_enable_in, // Cache control register enable
	input wire logic global_write_through_bit_in,
	input wire logic cached_region_copyback_bit_in,
	input wire logic [ASRD_ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier_in,
	input wire logic [ASRD_SA_W-1:0] assist_space_attribute_in, // Assist register
	input wire logic assist_timing_select_in, // Assist register
	input wire logic [ASRD_SA_W-1:0] dma_source_space_attribute_in,
	input wire logic [ASRD_SA_W-1:0] dma_dest_space_attribute_in,
	input wire logic dma_source_timing_select_in,
	input wire logic dma_dest_timing_select_in,
	input wire logic [ASRD_EXT_W-1:0] tlb_phys_addr_in, // Matched page address
	input wire logic page_cacheable_in,
	input wire logic page_write_through_bit_in,
	input wire logic [ASRD_SA_W-1:0] page_space_attribute_in,
	input wire logic page_timing_select_in,
	output logic resp_valid_out, // Decode result valid
	output asrd_region_e region_out,
	output asrd_window_e window_out,
	output logic translate_out, // Address went through the page lookup
	output logic [ASRD_ADDRESS_SPACE_IDENTIFIER_W-1:0] tlb_address_space_identifier_out, // Identifier of that lookup
	output logic cache_use_out,
	output logic write_through_out,
	output logic [ASRD_EXT_W-1:0] ext_addr_out,
	output logic [2:0] ext_area_out,
	output logic ctrl_reg_out, // Control register block
	output logic periph_reg_out, // Peripheral registers
	output logic reserved_out, // Reserved space hit
	output logic onchip_ram_out, // Hole window hit
	output logic addr_error_out,
	output logic pcmcia_out, // PCMCIA area access allowed
	output logic pcmcia_blocked_out,
	output logic [ASRD_SA_W-1:0] pcmcia_space_attribute_out,
	output logic pcmcia_timing_select_out
);

	// ------------------------------------------------------------
	// Region classification
	// ------------------------------------------------------------
	asrd_region_if rif();

	assign rif.addr = req_addr_in;

	asrd_region_classify u_classify (
		.rif(rif)
	);

	// Region flags
	wire r_low = (rif.region == ASRD_REG_LOW); // User or low privileged
	wire r_cached = (rif.region == ASRD_REG_CACHED);
	wire r_uncached = (rif.region == ASRD_REG_UNCACHED);
	wire r_third = (rif.region == ASRD_REG_THIRD);
	wire r_onchip = (rif.region == ASRD_REG_ONCHIP);
	wire w_sq = (rif.window == ASRD_WIN_SQ);
	wire at_on = translation_enable_bit_in;

	// ------------------------------------------------------------
	// Translation decision
	// ------------------------------------------------------------
	// DMA addresses are physical and never looked up
	wire tr_region = (r_low && !rif.ram_hole) || r_third;
	wire next_translate = at_on && !req_dma_in && (tr_region || w_sq);

	// Area of external space: bits 28:26 pick one of eight
	function automatic logic [2:0] area_of(input logic [ASRD_EXT_W-1:0] a);
		area_of = a[ASRD_EXT_W-1:ASRD_EXT_W-3];
	endfunction

	function automatic logic is_pcmcia(input logic [2:0] area);
		is_pcmcia = (area == ASRD_AREA_PCMCIA_A) || (area == ASRD_AREA_PCMCIA_B);
	endfunction

	// Untranslated addresses drop the top three bits
	wire [ASRD_EXT_W-1:0] direct_ext = req_addr_in[ASRD_EXT_W-1:0];
	wire [ASRD_EXT_W-1:0] next_ext = next_translate ? tlb_phys_addr_in : direct_ext;
	wire [2:0] next_area = area_of(next_ext);
	wire area7 = (next_area == ASRD_AREA_RESERVED);
	// I/O region has no external target, except the store queue when translated
	wire ext_target = !r_onchip || (w_sq && next_translate);

	// ------------------------------------------------------------
	// Control register and reserved routing
	// ------------------------------------------------------------
	// Translated hit on area 7 becomes the control register block
	wire ctrl_via_tlb = next_translate && !w_sq && area7;
	wire ctrl_direct = (rif.window == ASRD_WIN_CTRL);
	wire next_ctrl = ctrl_direct || ctrl_via_tlb;
	// Peripheral registers: top of I/O or translated area 7
	wire next_periph = (r_onchip && rif.periph) || ctrl_via_tlb;
	// Untranslated area 7 and reserved windows
	wire rsv_win = (rif.window == ASRD_WIN_RSV_LOW) || (rif.window == ASRD_WIN_RSV_HIGH);
	wire rsv_area = !r_onchip && !next_translate && area7;
	wire next_reserved = rsv_win || rsv_area;

	// ------------------------------------------------------------
	// Access rights
	// ------------------------------------------------------------
	// User may reach the low 2 Gbytes only, store queue aside
	wire user_high = req_user_in && !req_dma_in && !r_low && !w_sq;
	// Queue guarded by the privilege bit while untranslated
	wire user_sq = req_user_in && !req_dma_in && w_sq && !at_on &&
		store_queue_privilege_bit_in;
	wire next_error = user_high || user_sq;

	// ------------------------------------------------------------
	// Cache use and write policy
	// ------------------------------------------------------------
	// Untranslated: low, first cached and third regions may cache
	wire direct_cacheable = r_cached || (!at_on && (r_low || r_third) && !rif.ram_hole);
	// Translated: enable and page bit both needed
	wire page_cacheable = next_translate && !w_sq && page_cacheable_in;
	// Uncached region and I/O windows never qualify
	wire next_cache = cache_enable_in && !req_dma_in && !next_ctrl && !next_reserved &&
		(next_translate ? page_cacheable : direct_cacheable);
	// Copy-back bit set means copy-back, so write-through is its inverse
	wire direct_wt = r_cached ? !cached_region_copyback_bit_in : global_write_through_bit_in;
	wire next_wt = next_translate ? page_write_through_bit_in : direct_wt;

	// ------------------------------------------------------------
	// PCMCIA attributes
	// ------------------------------------------------------------
	wire pc_area = ext_target && is_pcmcia(next_area);
	// Untranslated privileged and I/O regions may not reach PCMCIA when mapping is on
	wire cpu_fixed_blk = at_on && (r_cached || r_uncached || r_onchip);
	// Early variant cannot reach PCMCIA from the core while untranslated
	wire cpu_legacy_blk = !at_on && LEGACY_VARIANT;
	wire next_pc_blocked = pc_area && !req_dma_in && (cpu_fixed_blk || cpu_legacy_blk);
	wire next_pc = pc_area && !next_pc_blocked;

	// Attribute source: DMA channel, page, or assist register
	logic [ASRD_SA_W-1:0] next_sa;
	logic next_tc;
	always_comb begin
		next_sa = '0;
		next_tc = 1'b0;
		if (next_pc) begin
			if (req_dma_in) begin
				// Channel fields regardless of translation
				next_sa = req_dma_dest_in ? dma_dest_space_attribute_in :
					dma_source_space_attribute_in;
				next_tc = req_dma_dest_in ? dma_dest_timing_select_in :
					dma_source_timing_select_in;
			end else if (next_translate) begin
				// Matched page fields
				next_sa = page_space_attribute_in;
				next_tc = page_timing_select_in;
			end else begin
				// Assist register fields
				next_sa = assist_space_attribute_in;
				next_tc = assist_timing_select_in;
			end
		end
	end

	// ------------------------------------------------------------
	// Result register
	// ------------------------------------------------------------
	// Valid strobe and error follow every request
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			resp_valid_out <= 1'b0;
			addr_error_out <= 1'b0;
		end else begin
			resp_valid_out <= req_valid_in;
			addr_error_out <= req_valid_in && next_error;
		end
	end

	// Classification fields, held between requests
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			region_out <= ASRD_REG_LOW;
			window_out <= ASRD_WIN_NONE;
			ext_addr_out <= '0;
			ext_area_out <= '0;
			tlb_address_space_identifier_out <= '0;
		end else if (req_valid_in) begin
			region_out <= rif.region;
			window_out <= rif.window;
			ext_addr_out <= next_ext;
			ext_area_out <= next_area;
			tlb_address_space_identifier_out <= next_translate ? address_space_identifier_in : '0;
		end
	end

	// Decision flags; a faulted access carries no side flags
	wire ok = req_valid_in && !next_error;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			translate_out <= 1'b0;
			cache_use_out <= 1'b0;
			write_through_out <= 1'b0;
			ctrl_reg_out <= 1'b0;
			periph_reg_out <= 1'b0;
			reserved_out <= 1'b0;
			onchip_ram_out <= 1'b0;
		end else begin
			translate_out <= ok && next_translate;
			cache_use_out <= ok && next_cache;
			write_through_out <= ok && next_cache && next_wt;
			ctrl_reg_out <= ok && next_ctrl;
			periph_reg_out <= ok && next_periph;
			reserved_out <= ok && next_reserved;
			onchip_ram_out <= ok && r_low && rif.ram_hole;
		end
	end

	// PCMCIA outputs
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pcmcia_out <= 1'b0;
			pcmcia_blocked_out <= 1'b0;
			pcmcia_space_attribute_out <= '0;
			pcmcia_timing_select_out <= 1'b0;
		end else begin
			pcmcia_out <= ok && next_pc;
			pcmcia_blocked_out <= ok && next_pc_blocked;
			pcmcia_space_attribute_out <= ok ? next_sa : '0;
			pcmcia_timing_select_out <= ok && next_tc;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_USER_HIGH_ERR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(req_valid_in && req_user_in && !req_dma_in && req_addr_in[31] &&
		req_addr_in[31:26] != ASRD_SQ_PREFIX) |=> addr_error_out)
		else $error("user access above 2 Gbytes not flagged");

	AST_SQ_GUARD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(req_valid_in && req_user_in && !req_dma_in && !translation_enable_bit_in &&
		req_addr_in[31:26] == ASRD_SQ_PREFIX) |=>
		(addr_error_out == $past(store_queue_privilege_bit_in)))
		else $error("store queue privilege check wrong");

	AST_NO_XLATE_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(req_valid_in && !translation_enable_bit_in) |=>
		(!translate_out && ext_addr_out == $past(req_addr_in[ASRD_EXT_W-1:0])))
		else $error("lookup used while translation disabled");

	AST_UNCACHED_REGION: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(req_valid_in && req_addr_in[31:29] == ASRD_TOP_UNCACHED) |=>
		(!cache_use_out && !translate_out))
		else $error("uncached region used cache or lookup");

	AST_RAM_HOLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(req_valid_in && !req_user_in && req_addr_in[31:26] == ASRD_RAM_PREFIX) |=>
		(onchip_ram_out && !cache_use_out && !translate_out))
		else $error("hole window cached or translated");

	AST_AREA7_CTRL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(translate_out && ext_area_out == ASRD_AREA_RESERVED &&
		window_out != ASRD_WIN_SQ) |-> (ctrl_reg_out && !reserved_out))
		else $error("translated area 7 not routed to control block");

	AST_PAGE_CACHE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(translate_out && window_out != ASRD_WIN_SQ && !ctrl_reg_out) |->
		(cache_use_out == ($past(cache_enable_in) && $past(page_cacheable_in))))
		else $error("translated cache use mismatch");

	AST_P1_POLICY: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(cache_use_out && region_out == ASRD_REG_CACHED) |->
		(write_through_out == !$past(cached_region_copyback_bit_in)))
		else $error("cached region write policy wrong");

	AST_DMA_ATTR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(req_valid_in && req_dma_in && req_dma_dest_in) ##1 pcmcia_out |->
		(pcmcia_space_attribute_out == $past(dma_dest_space_attribute_in)))
		else $error("DMA attribute source wrong");

	// Privileged only: a user access here already ends in an address error
	AST_FIXED_BLOCK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(req_valid_in && !req_dma_in && !req_user_in && translation_enable_bit_in &&
		req_addr_in[31:29] == ASRD_TOP_UNCACHED && is_pcmcia(req_addr_in[28:26])) |=>
		(pcmcia_blocked_out && !pcmcia_out))
		else $error("fixed region reached PCMCIA");

endmodule

/* sim/asrd_core_model.sv */
// Core-side page lookup model: answers the page lookup for each address.
// Assumes the bench drives the address and the page seed in one cycle.
`timescale 1ns/1ps

module asrd_core_model
	import asrd_pkg::*;
(
	input wire logic [ASRD_VA_W-1:0] addr_in,
	input wire logic [7:0] seed_in,
	input wire logic cache_enable_in,
	output logic [ASRD_EXT_W-1:0] phys_out,
	output logic cacheable_out,
	output logic write_through_out
);
	// ------------------------------------------------------------
	// Page frame
	// ------------------------------------------------------------
	wire logic [2:0] area = seed_in[7:5]; // Target area of the page
	wire logic pcm = (area == ASRD_AREA_PCMCIA_A) || (area == ASRD_AREA_PCMCIA_B);
	// Offset kept, so every page behaves like a 2-Mbyte frame
	assign phys_out = {area, seed_in[4:0], addr_in[20:0]};
	// Software never caches pages that map the control registers
	assign cacheable_out = seed_in[0] && (area != ASRD_AREA_RESERVED);
	// Card pages with caching on are write-through
	assign write_through_out = seed_in[1] || (pcm && cache_enable_in);
endmodule

/* sim/tb.sv */
// Bench for the region decoder: corner and random accesses, each one
// checked a cycle later against a bench model. Assumes default variant.
`timescale 1ns/1ps

module tb;
	import asrd_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk_in, sys_rst_in, req_valid_in, user, dma, dest, xlat_on, sq_priv, ce, gwt, cb;
	logic [31:0] addr, r;
	logic [7:0] space_id, seed_pg, sid_o;
	logic [2:0] asa, ssa, dsa, psa, area_o, sa_o;
	logic ats, sts, dts, pts, pend, pc, pw;
	logic rv, tro, cuo, wto, ctl, per, aerr, pcm, blk, tso, rsv, ram;
	logic [28:0] phys, ext_o;
	asrd_region_e reg_o;
	asrd_window_e win_o;
	int failures, cmp_count, seed;

	asrd_core_model core (.addr_in(addr), .seed_in(seed_pg), .cache_enable_in(ce),
		.phys_out(phys), .cacheable_out(pc), .write_through_out(pw));

	asrd_decoder dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
		.req_addr_in(addr), .req_user_in(user), .req_dma_in(dma), .req_dma_dest_in(dest),
		.translation_enable_bit_in(xlat_on), .store_queue_privilege_bit_in(sq_priv),
		.cache_enable_in(ce), .global_write_through_bit_in(gwt),
		.cached_region_copyback_bit_in(cb), .address_space_identifier_in(space_id),
		.assist_space_attribute_in(asa), .assist_timing_select_in(ats),
		.dma_source_space_attribute_in(ssa), .dma_dest_space_attribute_in(dsa),
		.dma_source_timing_select_in(sts), .dma_dest_timing_select_in(dts),
		.tlb_phys_addr_in(phys), .page_cacheable_in(pc), .page_write_through_bit_in(pw),
		.page_space_attribute_in(psa), .page_timing_select_in(pts),
		.resp_valid_out(rv), .region_out(reg_o), .window_out(win_o), .translate_out(tro),
		.tlb_address_space_identifier_out(sid_o), .cache_use_out(cuo), .write_through_out(wto),
		.ext_addr_out(ext_o), .ext_area_out(area_o), .ctrl_reg_out(ctl),
		.periph_reg_out(per), .reserved_out(rsv), .onchip_ram_out(ram), .addr_error_out(aerr),
		.pcmcia_out(pcm), .pcmcia_blocked_out(blk), .pcmcia_space_attribute_out(sa_o),
		.pcmcia_timing_select_out(tso));

	// Free-running 200 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string nm);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: %s got %h expected %h", $time, nm, got, exp);
		end
	endtask

	// Window expected inside the on-chip I/O region
	function automatic asrd_window_e exp_win(input logic [31:0] a);
		if (a[31:29] != ASRD_TOP_ONCHIP) return ASRD_WIN_NONE;
		case (a[28:26])
			3'h0: return ASRD_WIN_SQ;
			3'h4, 3'h5: return asrd_window_e'(ASRD_WIN_IC_ADDR + a[26:24]);
			3'h6: return ASRD_WIN_RSV_HIGH;
			3'h7: return ASRD_WIN_CTRL;
			default: return ASRD_WIN_RSV_LOW;
		endcase
	endfunction

	// Compares the answer to the request still on the inputs
	task automatic check();
		logic sq, hole, err, tq, tr, pm, cu, care, pce, a7, rs;
		logic [3:0] attr;
		logic [1:0] cr;
		logic [28:0] ext;
		asrd_region_e rg;
		asrd_window_e wn;
		sq = addr[31:26] == ASRD_SQ_PREFIX;
		hole = addr[31:26] == ASRD_RAM_PREFIX;
		rg = addr[31] ? asrd_region_e'(addr[31:29] - 3'h3) : ASRD_REG_LOW;
		wn = exp_win(addr);
		err = !dma && user && addr[31] && !(sq && !(!xlat_on && sq_priv));
		// Lookup asked for by the region; the identifier follows it even on error
		tq = !dma && xlat_on && ((rg == ASRD_REG_LOW && !hole) || rg == ASRD_REG_THIRD || sq);
		tr = !err && tq;
		ext = tr ? phys : addr[28:0];
		a7 = ext[28:26] == ASRD_AREA_RESERVED;
		pm = ext[28:26] == ASRD_AREA_PCMCIA_A || ext[28:26] == ASRD_AREA_PCMCIA_B;
		cu = !err && !dma && ce && !a7;
		cu = cu && (tr ? pc : (rg != ASRD_REG_UNCACHED && rg != ASRD_REG_ONCHIP));
		// Card hits in the cached region with the MMU on are left to the block flag
		care = !(tr && sq) && !(xlat_on && !dma && rg == ASRD_REG_CACHED && pm);
		pce = pm && (dma || tr || !xlat_on);
		attr = dma ? (dest ? {dts, dsa} : {sts, ssa}) : tr ? {pts, psa} : {ats, asa};
		cr = {addr[31:26] == ASRD_CTRL_PREFIX, addr[31:24] == ASRD_PERIPH_PREFIX};
		cr = tr ? {a7, a7} : cr;
		// Untranslated area 7 outside the I/O region, or a reserved I/O window
		rs = !tr && a7 && rg != ASRD_REG_ONCHIP;
		rs = rs || wn == ASRD_WIN_RSV_LOW || wn == ASRD_WIN_RSV_HIGH;
		cmp(rv, 1'b1, "valid");
		cmp(aerr, err, "error");
		cmp(reg_o, rg, "region");
		cmp(win_o, wn, "window");
		cmp(tro, tr, "translate");
		cmp(sid_o, tq ? space_id : 8'h00, "space id");
		if (!err) cmp({rsv, ram}, {rs, hole}, "reserved");
		if (!err && rg != ASRD_REG_ONCHIP) begin
			cmp(ext_o, ext, "ext addr");
			cmp(area_o, ext[28:26], "area");
			cmp(pcm, pce, "card");
			cmp(blk, pm && !dma && xlat_on && !tr, "blocked");
			if (pce) cmp({tso, sa_o}, attr, "attr");
		end
		if (care) cmp(cuo, cu, "cache");
		if (care && cu) cmp(wto, tr ? pw : (rg == ASRD_REG_CACHED ? !cb : gwt), "policy");
		if (!err && !sq) cmp({ctl, per}, cr, "ctrl");
	endtask

	// One cycle: check the last answer, then present the next request
	task automatic do_req(input logic [31:0] a, input logic u, d, v, input logic [2:0] m);
		@(posedge clk_in);
		#1;
		if (pend) check();
		else cmp({rv, cuo}, 2'b00, "idle");
		{xlat_on, sq_priv, ce} = m;
		{gwt, cb, dest, ats, sts, dts, pts} = $random(seed);
		{asa, ssa, dsa, psa} = $random(seed);
		space_id = $random(seed);
		seed_pg = $random(seed);
		addr = a;
		user = u;
		dma = d;
		req_valid_in = v;
		pend = v;
	endtask

	task automatic tally_and_finish();
		if (failures == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 47;
		failures = 0;
		cmp_count = 0;
		pend = 1'b0;
		{req_valid_in, user, dma, dest, xlat_on, sq_priv, ce, gwt, cb, ats, sts, dts, pts} = '0;
		{addr, space_id, seed_pg, asa, ssa, dsa, psa} = '0;
		sys_rst_in = 1'b1;
		repeat (8) @(posedge clk_in);
		#1;
		cmp({reg_o, win_o, rv}, {ASRD_REG_LOW, ASRD_WIN_NONE, 1'b0}, "reset");
		sys_rst_in = 1'b0;
		do_req(32'h8000_1000, 0, 0, 1, 3'h1);
		do_req(32'hA000_0000, 1, 0, 1, 3'h1);
		do_req(32'hE000_0000, 1, 0, 1, 3'h2);
		do_req(32'hE3FF_FFFC, 1, 0, 1, 3'h0);
		for (int i = 0; i < 8; i++) do_req(32'hF000_0000 + (i << 24), 0, 0, 1, 3'h5);
		do_req(32'hFF00_0000, 0, 0, 1, 3'h4);
		do_req(32'hFC00_0000, 0, 0, 1, 3'h4);
		do_req(32'h7C00_0000, 1, 0, 1, 3'h5);
		do_req(32'h1400_0000, 0, 1, 1, 3'h5);
		do_req(32'hB800_0000, 0, 0, 1, 3'h5);
		do_req(32'h1800_0000, 0, 0, 1, 3'h1);
		// Random traffic, back to back with idle gaps; DMA stays physical
		repeat (3000) begin
			r = $random(seed);
			do_req((r[0] & r[1]) ? {1'b0, r[31:1]} : r, r[2], r[0] & r[1], r[3] | r[4], r[7:5]);
		end
		do_req(32'h0000_0000, 0, 0, 0, 3'h0);
		tally_and_finish();
	end
endmodule
